/* fcde_unit.sv */
`timescale 1ns/100ps
`include "fcde_cfg.svh"

// Summary of operation
// RULE1: compare decoded by opcode and opf
// RULE2: bits 26:25 pick condition field
// RULE3: codes equal 0, less 1, greater 2, unordered 3
// RULE4: any NaN operand means unordered
// RULE5: trapping compare flags invalid on any NaN
// RULE6: plain compare flags invalid on signalling NaN
// RULE7: condition code visible to next instruction
// RULE8: compare reserved bits nonzero is illegal
// RULE9: quad compares trap as illegal
// RULE10: unit off or disabled raises disabled
// RULE11: quad compare odd register raises misc (code checks bit 1 of rs1 and rs2, not bit 0)
// RULE12: divide decode, quotient to destination
// RULE13: quotient rounded by rounding direction
// RULE14: quad divide traps as illegal
// RULE15: unusual divide operands raise incomplete operation
// RULE16: expand four bytes shifted into lanes
// RULE17: lanes written as one 64-bit result
// RULE18: expand unused source bits nonzero illegal
// RULE19: exceptions leave destination and codes unchanged
module fcde_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue and completion
  input wire fcde_pkg::fcde_issue_type issue,
  output logic issue_ready,
  output fcde_pkg::fcde_result_type result,
  output logic [7:0] fcc,
  // register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq
);
  // ****************
  // helpers
  // ****************
  function automatic logic is_nan(input logic [63:0] x, input logic dbl);
    return dbl ? (&x[62:52] && |x[51:0]) : (&x[30:23] && |x[22:0]);
  endfunction : is_nan

  function automatic fcde_pkg::fcde_unpk_type unpack(input logic [63:0] x, input logic dbl);
    fcde_pkg::fcde_unpk_type u;
    logic [10:0] e;
    logic [51:0] f;
    e = dbl ? x[62:52] : {3'h0, x[30:23]};
    f = dbl ? x[51:0] : {x[22:0], 29'h0};
    u.sign = dbl ? x[63] : x[31];
    u.exp = dbl ? {3'h0, e} : {3'h0, e} + `FCDE_REBIAS;
    u.mant = {1'b1, f};
    u.nan = is_nan(x, dbl);
    u.snan = u.nan & ~f[51];
    u.inf = (dbl ? &e : &e[7:0]) & ~|f;
    u.zero = ~|e & ~|f;
    u.den = ~|e & |f;
    return u;
  endfunction : unpack

  // raw magnitude order matches numeric order for two positive operands, reversed for two negative
  function automatic logic [1:0] fcc_of(input logic [63:0] a, input logic [63:0] b,
                                        input logic dbl);
    logic sa;
    logic sb;
    logic [62:0] ma;
    logic [62:0] mb;
    sa = dbl ? a[63] : a[31];
    sb = dbl ? b[63] : b[31];
    ma = dbl ? a[62:0] : {32'h0, a[30:0]};
    mb = dbl ? b[62:0] : {32'h0, b[30:0]};
    if (is_nan(a, dbl) || is_nan(b, dbl)) return `FCDE_FCC_UN;
    if (ma == mb && (sa == sb || ma == 63'h0)) return `FCDE_FCC_EQ;
    if (sa != sb) return sa ? `FCDE_FCC_LT : `FCDE_FCC_GT;
    return ((ma < mb) ^ sa) ? `FCDE_FCC_LT : `FCDE_FCC_GT;
  endfunction : fcc_of

  function automatic logic [63:0] expand(input logic [31:0] x);
    logic [63:0] r;
    r = 64'h0;
    for (int i = 0; i < 4; i++) begin
      r[16*i +: 16] = {4'h0, x[8*i +: 8], 4'h0};
    end
    return r;
  endfunction : expand

  function automatic logic [63:0] special(input logic s, input logic inf, input logic dbl);
    if (dbl) return {s, inf ? 11'h7ff : 11'h000, 52'h0};
    return {32'h0, s, inf ? 8'hff : 8'h00, 23'h0};
  endfunction : special

  function automatic logic in_range(input logic [13:0] v, input logic [13:0] max);
    return !v[13] && v != 14'h0 && v <= max;
  endfunction : in_range

  // ****************
  // state
  // ****************
  fcde_pkg::fcde_state_type state_reg;
  fcde_pkg::fcde_result_type result_reg;
  fcde_pkg::fcde_result_type imm;
  fcde_pkg::fcde_result_type rnd;
  fcde_pkg::fcde_unpk_type ua;
  fcde_pkg::fcde_unpk_type ub;
  fcde_pkg::fcde_exc_type exc_now;
  logic [7:0] fcc_reg;
  logic [5:0] ctrl_reg;
  logic [2:0] ftt_reg;
  logic [4:0] stat_reg;
  logic [4:0] mask_reg;
  logic [4:0] stat_ev;
  logic [4:0] stat_clr;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [54:0] rem_reg;
  logic [52:0] dvs_reg;
  logic [55:0] q_reg;
  logic [5:0] cnt_reg;
  logic [13:0] exp_reg;
  logic sign_reg;
  logic dbl_reg;
  logic [1:0] rdir_reg;
  logic [4:0] rd_reg;
  logic [31:0] insn;
  logic [8:0] opf;
  logic fmt_ok;
  logic go;
  logic is_cmp;
  logic is_div;
  logic is_exp;
  logic quad;
  logic dbl;
  logic trapping;
  logic nan_any;
  logic snan_any;
  logic start_div;
  logic [1:0] sel;
  logic bus_wr;
  logic bus_rd;

  // ****************
  // decode
  // ****************
  always_comb begin
    insn = issue.insn;
    opf = insn[`FCDE_F_OPF];
    fmt_ok = insn[`FCDE_F_OP] == `FCDE_OP_FMT;
    // RULE1 compare decode
    is_cmp = fmt_ok && insn[`FCDE_F_MAJ] == `FCDE_MAJ_CMP && opf[`FCDE_F_GRP] == `FCDE_GRP_CMP
             && !opf[3] && opf[`FCDE_F_PREC] != 2'h0;
    // RULE12 divide decode
    is_div = fmt_ok && insn[`FCDE_F_MAJ] == `FCDE_MAJ_ARITH && (opf == `FCDE_OPF_DIV_S
             || opf == `FCDE_OPF_DIV_D || opf == `FCDE_OPF_DIV_Q);
    is_exp = fmt_ok && insn[`FCDE_F_MAJ] == `FCDE_MAJ_EXP && opf == `FCDE_OPF_EXP;
    quad = opf[`FCDE_F_PREC] == `FCDE_PREC_Q;
    dbl = opf[`FCDE_F_PREC] == `FCDE_PREC_D;
    trapping = opf[`FCDE_B_TRAP];
    // RULE2 field selector
    sel = insn[`FCDE_F_SEL];
    ua = unpack(issue.src1, dbl);
    ub = unpack(issue.src2, dbl);
    // RULE4 unordered on any nan
    nan_any = ua.nan | ub.nan;
    snan_any = ua.snan | ub.snan;
    if (!(is_cmp || is_div || is_exp)) begin
      exc_now = fcde_pkg::FCDE_EXC_ILLEGAL;
    // RULE8 RULE18 reserved fields
    end else if ((is_cmp && insn[`FCDE_F_RSV] != 3'h0)
                 || (is_exp && insn[`FCDE_F_RS1] != 5'h0)) begin
      exc_now = fcde_pkg::FCDE_EXC_ILLEGAL;
    // RULE10 unit disabled
    end else if (!ctrl_reg[`FCDE_C_PRESENT] || !ctrl_reg[`FCDE_C_USER]
                 || !ctrl_reg[`FCDE_C_STATE]) begin
      exc_now = fcde_pkg::FCDE_EXC_OFF;
    // RULE11 quad register with bit 1 of rs1 or rs2 set
    end else if (is_cmp && quad && (insn[`FCDE_B_RS1_1] || insn[`FCDE_B_RS2_1])) begin
      exc_now = fcde_pkg::FCDE_EXC_MISC;
    // RULE9 RULE14 quad left to software
    end else if ((is_cmp || is_div) && quad) begin
      exc_now = fcde_pkg::FCDE_EXC_ILLEGAL;
    end else begin
      exc_now = fcde_pkg::FCDE_EXC_NONE;
    end
  end

  assign issue_ready = state_reg == fcde_pkg::FCDE_IDLE;
  assign go = issue.valid && issue_ready;

  // ****************
  // single-cycle results
  // ****************
  always_comb begin
    imm = '0;
    imm.valid = 1'b1;
    imm.rd = insn[`FCDE_F_RD];
    imm.exc = exc_now;
    start_div = 1'b0;
    if (exc_now == fcde_pkg::FCDE_EXC_MISC) begin
      imm.ftt = `FCDE_FTT_BADREG;
    end
    if (exc_now == fcde_pkg::FCDE_EXC_NONE) begin
      if (is_cmp) begin
        // RULE5 RULE6 invalid by variant
        imm.nv = trapping ? nan_any : snan_any;
      end else if (is_exp) begin
        // RULE16 RULE17 expand lanes
        imm.wr = 1'b1;
        imm.data = expand(issue.src2[31:0]);
      end else if (nan_any || (ua.zero && ub.zero) || (ua.inf && ub.inf)) begin
        imm.wr = 1'b1;
        imm.nv = snan_any || !nan_any;
        imm.data = dbl ? `FCDE_QNAN_D : {32'h0, `FCDE_QNAN_S};
      end else if (ua.den || ub.den) begin
        // RULE15 subnormal operands not handled
        imm.exc = fcde_pkg::FCDE_EXC_MISC;
        imm.ftt = `FCDE_FTT_UNFIN;
      end else if (ua.inf || ub.zero) begin
        imm.wr = 1'b1;
        imm.dz = ub.zero;
        imm.data = special(ua.sign ^ ub.sign, 1'b1, dbl);
      end else if (ua.zero || ub.inf) begin
        imm.wr = 1'b1;
        imm.data = special(ua.sign ^ ub.sign, 1'b0, dbl);
      end else begin
        imm.valid = 1'b0;
        start_div = 1'b1;
      end
      // RULE19 trapped invalid writes nothing
      if (imm.nv && ctrl_reg[`FCDE_C_NVTRAP]) begin
        imm.exc = fcde_pkg::FCDE_EXC_IEEE;
        imm.ftt = `FCDE_FTT_IEEE;
        imm.wr = 1'b0;
      end
    end
  end

  // ****************
  // divider
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= fcde_pkg::FCDE_IDLE;
    end else begin
      unique case (state_reg)
        fcde_pkg::FCDE_IDLE: if (go && start_div) state_reg <= fcde_pkg::FCDE_DIV;
        fcde_pkg::FCDE_DIV: if (cnt_reg == `FCDE_DIV_LAST) state_reg <= fcde_pkg::FCDE_RND;
        fcde_pkg::FCDE_RND: state_reg <= fcde_pkg::FCDE_IDLE;
      endcase
    end
  end

  // one quotient bit per cycle keeps the area small at the cost of latency
  always_ff @(posedge clk) begin
    if (go && start_div) begin
      rem_reg <= {2'h0, ua.mant};
      dvs_reg <= ub.mant;
      q_reg <= 56'h0;
      cnt_reg <= 6'h0;
      exp_reg <= ua.exp - ub.exp + `FCDE_BIAS_D;
      sign_reg <= ua.sign ^ ub.sign;
      dbl_reg <= dbl;
      rdir_reg <= ctrl_reg[`FCDE_C_RDIR];
      rd_reg <= insn[`FCDE_F_RD];
    end else if (state_reg == fcde_pkg::FCDE_DIV) begin
      q_reg <= {q_reg[54:0], rem_reg >= {2'h0, dvs_reg}};
      rem_reg <= rem_reg >= {2'h0, dvs_reg} ? {rem_reg[53:0] - {1'b0, dvs_reg}, 1'b0}
                                            : {rem_reg[53:0], 1'b0};
      cnt_reg <= cnt_reg + 6'h1;
    end
  end

  always_comb begin
    logic [55:0] qn;
    logic [13:0] en;
    logic [13:0] ef;
    logic [13:0] es;
    logic [52:0] keep;
    logic [53:0] sum;
    logic g;
    logic st;
    logic inc;
    logic cy;
    inc = 1'b0;
    qn = q_reg[55] ? q_reg : {q_reg[54:0], 1'b0};
    en = q_reg[55] ? exp_reg : exp_reg - 14'h1;
    keep = dbl_reg ? qn[55:3] : {29'h0, qn[55:32]};
    g = dbl_reg ? qn[2] : qn[31];
    st = (dbl_reg ? |qn[1:0] : |qn[30:0]) | (|rem_reg);
    // RULE13 rounding direction
    unique case (rdir_reg)
      `FCDE_RND_NEAR: inc = g & (st | keep[0]);
      `FCDE_RND_ZERO: inc = 1'b0;
      `FCDE_RND_POS: inc = ~sign_reg & (g | st);
      `FCDE_RND_NEG: inc = sign_reg & (g | st);
    endcase
    sum = {1'b0, keep} + {53'h0, inc};
    cy = dbl_reg ? sum[53] : sum[24];
    ef = en + {13'h0, cy};
    es = ef - `FCDE_REBIAS;
    rnd = '0;
    rnd.valid = 1'b1;
    rnd.rd = rd_reg;
    if (dbl_reg ? in_range(ef, `FCDE_EMAX_D) : in_range(es, `FCDE_EMAX_S)) begin
      rnd.wr = 1'b1;
      rnd.data = dbl_reg ? {sign_reg, ef[10:0], sum[51:0]}
                         : {32'h0, sign_reg, es[7:0], sum[22:0]};
    end else begin
      // RULE15 overflow and underflow left to software
      rnd.exc = fcde_pkg::FCDE_EXC_MISC;
      rnd.ftt = `FCDE_FTT_UNFIN;
    end
  end

  // ****************
  // results and condition codes
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= '0;
    end else if (go && !start_div) begin
      result_reg <= imm;
    end else if (state_reg == fcde_pkg::FCDE_RND) begin
      result_reg <= rnd;
    end else begin
      result_reg <= '0;
    end
  end
  assign result = result_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      fcc_reg <= 8'h0;
    // RULE3 RULE7 code written at completion edge
    end else if (go && is_cmp && imm.exc == fcde_pkg::FCDE_EXC_NONE) begin
      fcc_reg[{sel, 1'b0} +: 2] <= fcc_of(issue.src1, issue.src2, dbl);
    end
  end
  assign fcc = fcc_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ftt_reg <= `FCDE_FTT_NONE;
    end else if (result_reg.valid && result_reg.exc != fcde_pkg::FCDE_EXC_NONE) begin
      ftt_reg <= result_reg.ftt;
    end
  end

  // ****************
  // register bus
  // ****************
  // one wait state: data is fetched on the first cycle, handed over on the second
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign bus_wr = avs_write && ack_reg;
  assign bus_rd = avs_read && ack_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
      if (avs_read && !ack_reg) begin
        case (avs_address)
          `FCDE_REG_CTRL: rdata_reg <= {26'h0, ctrl_reg};
          `FCDE_REG_FCC: rdata_reg <= {24'h0, fcc_reg};
          `FCDE_REG_TRAP: rdata_reg <= {29'h0, ftt_reg};
          `FCDE_REG_STAT: rdata_reg <= {27'h0, stat_reg};
          `FCDE_REG_MASK: rdata_reg <= {27'h0, mask_reg};
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `FCDE_CTRL_RST;
      mask_reg <= 5'h0;
    end else if (bus_wr && avs_address == `FCDE_REG_CTRL) begin
      ctrl_reg <= avs_writedata[5:0];
    end else if (bus_wr && avs_address == `FCDE_REG_MASK) begin
      mask_reg <= avs_writedata[4:0];
    end
  end

  // only bits already shown to software are cleared, so a late event survives
  assign stat_clr = (bus_rd && avs_address == `FCDE_REG_STAT) ? rdata_reg[4:0] : 5'h0;
  assign stat_ev = {result_reg.valid, result_reg.nv,
                    result_reg.valid && result_reg.exc == fcde_pkg::FCDE_EXC_MISC,
                    result_reg.valid && result_reg.exc == fcde_pkg::FCDE_EXC_OFF,
                    result_reg.valid && result_reg.exc == fcde_pkg::FCDE_EXC_ILLEGAL};

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= 5'h0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_ev;
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // ****************
  // assertions
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_cmp_latency: assert property ( // RULE7
    go && is_cmp |=> result_reg.valid && !result_reg.wr) else $error("compare result late");
  a_cmp_unordered: assert property ( // RULE3
    go && is_cmp && nan_any && imm.exc == fcde_pkg::FCDE_EXC_NONE
    |=> fcc_reg[{$past(sel), 1'b0} +: 2] == `FCDE_FCC_UN) else $error("unordered code wrong");
  a_trap_nan: assert property ( // RULE5
    go && is_cmp && trapping && nan_any && exc_now == fcde_pkg::FCDE_EXC_NONE
    |=> result_reg.nv) else $error("trapping compare missed invalid");
  a_plain_qnan: assert property ( // RULE6
    go && is_cmp && !trapping && !snan_any |=> !result_reg.nv) else $error("quiet nan flagged");
  a_rsv_illegal: assert property ( // RULE8
    go && is_cmp && insn[`FCDE_F_RSV] != 3'h0
    |=> result_reg.exc == fcde_pkg::FCDE_EXC_ILLEGAL) else $error("reserved bits accepted");
  a_unit_off: assert property ( // RULE10
    go && (is_cmp || is_div) && !ctrl_reg[`FCDE_C_PRESENT] && !quad
    && insn[`FCDE_F_RSV] == 3'h0 |=> result_reg.exc == fcde_pkg::FCDE_EXC_OFF)
    else $error("disabled unit executed");
  a_bad_quad_reg: assert property ( // RULE11
    go && is_cmp && quad && exc_now != fcde_pkg::FCDE_EXC_OFF && insn[`FCDE_F_RSV] == 3'h0
    && insn[`FCDE_B_RS2_1] |=> result_reg.ftt == `FCDE_FTT_BADREG) else $error("bad reg missed");
  a_quad_div: assert property ( // RULE14
    go && is_div && quad && &ctrl_reg[2:0]
    |=> result_reg.exc == fcde_pkg::FCDE_EXC_ILLEGAL) else $error("quad divide executed");
  a_expand_lane: assert property ( // RULE16
    go && is_exp && exc_now == fcde_pkg::FCDE_EXC_NONE
    |=> result_reg.wr && result_reg.data[31:16] == {4'h0, $past(issue.src2[15:8]), 4'h0})
    else $error("expand lane wrong");
  a_exc_no_write: assert property ( // RULE19
    result_reg.valid && result_reg.exc != fcde_pkg::FCDE_EXC_NONE
    |-> !result_reg.wr && $stable(fcc_reg)) else $error("exception wrote state");
  a_div_timing: assert property ( // RULE12
    go && start_div |=> !issue_ready [*8] ##50 result_reg.valid) else $error("divide timing");

  c_cmp_nan: cover property (go && is_cmp && nan_any);
  c_div_done: cover property (state_reg == fcde_pkg::FCDE_RND && rnd.wr);
  c_expand: cover property (go && is_exp && exc_now == fcde_pkg::FCDE_EXC_NONE);
  c_irq: cover property (irq);
endmodule : fcde_unit

/* fcde_cfg.svh */
`ifndef FCDE_CFG_SVH
`define FCDE_CFG_SVH
// ****************
// instruction fields
// ****************
`define FCDE_F_OP 31:30
`define FCDE_F_RSV 29:27
`define FCDE_F_SEL 26:25
`define FCDE_F_RD 29:25
`define FCDE_F_MAJ 24:19
`define FCDE_F_RS1 18:14
`define FCDE_F_OPF 13:5
`define FCDE_F_GRP 8:4
`define FCDE_F_PREC 1:0
`define FCDE_B_TRAP 2
`define FCDE_B_RS1_1 15
`define FCDE_B_RS2_1 1
// ****************
// encodings
// ****************
`define FCDE_OP_FMT 2'h2
`define FCDE_MAJ_CMP 6'h35
`define FCDE_MAJ_ARITH 6'h34
`define FCDE_MAJ_EXP 6'h36
`define FCDE_GRP_CMP 5'h05
`define FCDE_OPF_DIV_S 9'h04d
`define FCDE_OPF_DIV_D 9'h04e
`define FCDE_OPF_DIV_Q 9'h04f
`define FCDE_OPF_EXP 9'h04d
`define FCDE_PREC_D 2'h2
`define FCDE_PREC_Q 2'h3
`define FCDE_FCC_EQ 2'h0
`define FCDE_FCC_LT 2'h1
`define FCDE_FCC_GT 2'h2
`define FCDE_FCC_UN 2'h3
`define FCDE_RND_NEAR 2'h0
`define FCDE_RND_ZERO 2'h1
`define FCDE_RND_POS 2'h2
`define FCDE_RND_NEG 2'h3
// ****************
// arithmetic
// ****************
`define FCDE_BIAS_D 14'h03ff
`define FCDE_REBIAS 14'h0380
`define FCDE_EMAX_D 14'h07fe
`define FCDE_EMAX_S 14'h00fe
`define FCDE_QNAN_D 64'h7fff_ffff_ffff_ffff
`define FCDE_QNAN_S 32'h7fff_ffff
`define FCDE_DIV_LAST 6'h37
`define FCDE_FTT_NONE 3'h0
`define FCDE_FTT_IEEE 3'h1
`define FCDE_FTT_UNFIN 3'h2
`define FCDE_FTT_BADREG 3'h3
// ****************
// registers
// ****************
`define FCDE_REG_CTRL 5'h00
`define FCDE_REG_FCC 5'h04
`define FCDE_REG_TRAP 5'h08
`define FCDE_REG_STAT 5'h0c
`define FCDE_REG_MASK 5'h10
`define FCDE_CTRL_RST 6'h01
`define FCDE_C_PRESENT 0
`define FCDE_C_USER 1
`define FCDE_C_STATE 2
`define FCDE_C_RDIR 4:3
`define FCDE_C_NVTRAP 5
`endif

/* fcde_pkg.sv */
package fcde_pkg;
  typedef enum logic [2:0] {
    FCDE_EXC_NONE, FCDE_EXC_ILLEGAL, FCDE_EXC_OFF, FCDE_EXC_MISC, FCDE_EXC_IEEE
  } fcde_exc_type;
  typedef enum {FCDE_IDLE, FCDE_DIV, FCDE_RND} fcde_state_type;
  typedef struct packed {
    logic valid;
    logic [31:0] insn;
    logic [63:0] src1;
    logic [63:0] src2;
  } fcde_issue_type;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [4:0] rd;
    logic [63:0] data;
    fcde_exc_type exc;
    logic [2:0] ftt;
    logic nv;
    logic dz;
  } fcde_result_type;
  typedef struct packed {
    logic sign;
    logic [13:0] exp;
    logic [52:0] mant;
    logic nan;
    logic snan;
    logic inf;
    logic zero;
    logic den;
  } fcde_unpk_type;
endpackage : fcde_pkg

/* fcde_issue_model.sv */
`timescale 1ns/100ps
module fcde_issue_model (
  // clock
  input wire logic clk,
  // issue side of the unit
  output fcde_pkg::fcde_issue_type issue,
  input wire logic issue_ready,
  input wire fcde_pkg::fcde_result_type result
);
  initial issue = '0;
  // ****************
  // one instruction, sent whole
  // ****************
  // no gap required
  task automatic send(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b,
      output fcde_pkg::fcde_result_type r, output bit late);
    int n;
    n = 0;
    issue <= '{valid: 1'b1, insn: i, src1: a, src2: b};
    // taken at the edge that sees ready high
    do begin
      @(posedge clk);
      n++;
    end while (issue_ready !== 1'b1 && n < 100);
    // released fields invert so stale values cannot match
    issue <= '{valid: 1'b0, insn: ~i, src1: ~a, src2: ~b};
    do begin
      @(posedge clk);
      n++;
    end while (result.valid !== 1'b1 && n < 200);
    r = result;
    late = (result.valid !== 1'b1);
  endtask : send
endmodule : fcde_issue_model

/* tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fcde_pkg::fcde_issue_type issue;
  fcde_pkg::fcde_result_type result;
  fcde_pkg::fcde_result_type r;
  logic issue_ready;
  logic [7:0] fcc;
  logic [7:0] exp_fcc = 8'h00;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  logic irq;
  logic [63:0] a;
  logic [63:0] b;
  logic [63:0] msk;
  logic [1:0] sel;
  logic dbl;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 45691;
  bit late;
  logic [31:0] bad[7];
  fcde_pkg::fcde_exc_type bad_exc[7];
  logic [63:0] third[4] = '{64'h3fd5_5555_5555_5555, 64'h3fd5_5555_5555_5555,
    64'h3fd5_5555_5555_5556, 64'h3fd5_5555_5555_5555};
  always #2.5 clk = ~clk;
  fcde_unit DUT (.clk(clk), .rst(rst), .issue(issue), .issue_ready(issue_ready),
    .result(result), .fcc(fcc), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  fcde_issue_model pm (.clk(clk), .issue(issue), .issue_ready(issue_ready), .result(result));
  // ****************
  // helpers
  // ****************
  task automatic test_done;
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // request stands until the edge that samples waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle cycle keeps requests apart
    @(posedge clk);
    if (n >= 50) begin
      miscompares++;
      test_done();
    end
  endtask : bus
  task automatic ex(input logic [31:0] i, input logic [63:0] x, input logic [63:0] y);
    pm.send(i, x, y, r, late);
    if (late) begin
      miscompares++;
      test_done();
    end
  endtask : ex
  function automatic logic [31:0] enc(input logic [5:0] maj, input logic [4:0] dst,
      input logic [4:0] s1, input logic [8:0] opf, input logic [4:0] s2);
    return {2'h2, dst, maj, s1, opf, s2};
  endfunction : enc
  // ordering of non-negative finite values follows their bit patterns
  function automatic logic [1:0] rel(input logic [63:0] x, input logic [63:0] y);
    if (x == y) return 2'h0;
    return (x < y) ? 2'h1 : 2'h2;
  endfunction : rel
  function automatic logic [63:0] lanes(input logic [31:0] s);
    logic [63:0] v;
    for (int i = 0; i < 4; i++) v[16*i +: 16] = {4'h0, s[8*i +: 8], 4'h0};
    return v;
  endfunction : lanes
  // ****************
  // main sequence
  // ****************
  initial begin
    bad = '{enc(6'h35, 5'h04, 5'h0, 9'h051, 5'h0), enc(6'h35, 5'h00, 5'h0, 9'h053, 5'h0),
      enc(6'h35, 5'h00, 5'h0, 9'h057, 5'h0), enc(6'h35, 5'h00, 5'h02, 9'h053, 5'h0),
      enc(6'h35, 5'h00, 5'h0, 9'h057, 5'h02), enc(6'h34, 5'h01, 5'h0, 9'h04f, 5'h0),
      enc(6'h36, 5'h01, 5'h01, 9'h04d, 5'h0)};
    bad_exc = '{fcde_pkg::FCDE_EXC_ILLEGAL, fcde_pkg::FCDE_EXC_ILLEGAL,
      fcde_pkg::FCDE_EXC_ILLEGAL, fcde_pkg::FCDE_EXC_MISC, fcde_pkg::FCDE_EXC_MISC,
      fcde_pkg::FCDE_EXC_ILLEGAL, fcde_pkg::FCDE_EXC_ILLEGAL};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 5'h00, 32'h0);
    `CHK(rd, 32'h0000_0001)
    foreach (third[k]) begin
      if (k == 3) break;
      bus(1'b1, 5'h00, 32'h7 ^ (32'h1 << k));
      ex(enc(6'h35, 5'h00, 5'h0, 9'h051, 5'h0), 64'h0, 64'h0);
      `CHK(r.exc, fcde_pkg::FCDE_EXC_OFF)
      ex(enc(6'h34, 5'h01, 5'h0, 9'h04d, 5'h0), 64'h3f80_0000, 64'h3f80_0000);
      `CHK(r.exc, fcde_pkg::FCDE_EXC_OFF)
      ex(enc(6'h36, 5'h01, 5'h0, 9'h04d, 5'h0), 64'h0, 64'h1234_5678);
      `CHK(r.exc, fcde_pkg::FCDE_EXC_OFF)
      `CHK(fcc, exp_fcc)
    end
    bus(1'b1, 5'h00, 32'h7);
    bus(1'b1, 5'h10, 32'h1f);
    for (int k = 0; k < 16; k++) begin
      sel = 2'($random(seed));
      dbl = 1'($random(seed));
      msk = dbl ? 64'h3fff_ffff_ffff_ffff : 64'h3fff_ffff;
      a = {32'($random(seed)), 32'($random(seed))} & msk;
      b = (k % 4 == 0) ? a : {32'($random(seed)), 32'($random(seed))} & msk;
      ex(enc(6'h35, {3'h0, sel}, 5'h0, 9'h051 + 9'(dbl) + 9'(k[0] ? 4 : 0), 5'h0), a, b);
      exp_fcc[2*sel +: 2] = rel(a, b);
      `CHK(r.exc, fcde_pkg::FCDE_EXC_NONE)
      `CHK(fcc, exp_fcc)
    end
    // trapped invalid leaves the code alone
    bus(1'b1, 5'h00, 32'h27);
    ex(enc(6'h35, 5'h00, 5'h0, 9'h055, 5'h0), 64'h7fc0_0000, 64'h0);
    `CHK(r.exc, fcde_pkg::FCDE_EXC_IEEE)
    `CHK(r.ftt, 3'h1)
    `CHK(r.wr, 1'b0)
    `CHK(fcc, exp_fcc)
    bus(1'b1, 5'h00, 32'h7);
    ex(enc(6'h35, 5'h00, 5'h0, 9'h051, 5'h0), 64'h7fc0_0000, 64'h3f80_0000);
    `CHK(r.nv, 1'b0)
    ex(enc(6'h35, 5'h01, 5'h0, 9'h051, 5'h0), 64'h3f80_0000, 64'h7f80_0001);
    `CHK(r.nv, 1'b1)
    ex(enc(6'h35, 5'h02, 5'h0, 9'h055, 5'h0), 64'h7fc0_0000, 64'h3f80_0000);
    `CHK(r.nv, 1'b1)
    ex(enc(6'h35, 5'h03, 5'h0, 9'h056, 5'h0), 64'h7ff8_0000_0000_0000, 64'h0);
    `CHK(r.nv, 1'b1)
    exp_fcc = 8'hff;
    `CHK(fcc, exp_fcc)
    bus(1'b0, 5'h04, 32'h0);
    `CHK(rd, 32'h0000_00ff)
    `CHK(irq, 1'b1)
    bus(1'b0, 5'h0c, 32'h0);
    `CHK(rd[3], 1'b1)
    `CHK(irq, 1'b0)
    bus(1'b1, 5'h10, 32'h1);
    foreach (bad[k]) begin
      ex(bad[k], 64'h3f80_0000, 64'h4000_0000);
      `CHK(r.exc, bad_exc[k])
      `CHK(r.wr, 1'b0)
      `CHK(fcc, exp_fcc)
      if (k == 3) begin
        `CHK(r.ftt, 3'h3)
        bus(1'b0, 5'h08, 32'h0);
        `CHK(rd[2:0], 3'h3)
      end
    end
    `CHK(irq, 1'b1)
    bus(1'b0, 5'h0c, 32'h0);
    bus(1'b0, 5'h1c, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'b0)
    ex(enc(6'h34, 5'h03, 5'h01, 9'h04d, 5'h02), 64'h40c0_0000, 64'h4000_0000);
    `CHK(r.data, 64'h4040_0000)
    `CHK(r.rd, 5'h03)
    `CHK(r.wr, 1'b1)
    foreach (third[m]) begin
      bus(1'b1, 5'h00, 32'h7 | (32'(m) << 3));
      ex(enc(6'h34, 5'h04, 5'h01, 9'h04e, 5'h02), 64'h3ff0_0000_0000_0000,
        64'h4008_0000_0000_0000);
      `CHK(r.data, third[m])
    end
    ex(enc(6'h34, 5'h05, 5'h01, 9'h04d, 5'h02), 64'h0000_0001, 64'h4000_0000);
    `CHK(r.exc, fcde_pkg::FCDE_EXC_MISC)
    `CHK(r.ftt, 3'h2)
    `CHK(r.wr, 1'b0)
    ex(enc(6'h34, 5'h07, 5'h01, 9'h04d, 5'h02), 64'hbf80_0000, 64'h0);
    `CHK(r.data, 64'hff80_0000)
    `CHK(r.dz, 1'b1)
    for (int k = 0; k < 6; k++) begin
      a = 64'(32'($random(seed)));
      ex(enc(6'h36, 5'h06, 5'h0, 9'h04d, 5'h03), 64'h0, a);
      `CHK(r.data, lanes(a[31:0]))
      `CHK(r.wr, 1'b1)
    end
    test_done();
  end
endmodule : tb_top
